//--- pieb_pkg.sv
// Constants, register map and carrier types for the peripheral interrupt
// enable and request-flag bank.
// Assumes one 100 MHz clock and an AXI4-Lite master, 32-bit data.
//
// Function
// - Request flags set on their events regardless of any enable bit.
// - Sources behind enable registers one to eight need the peripheral enable.
// - Change-detect summary flag is read-only OR of all per-port change flags.
// - Timer zero overflow sets flag register 0 bit 5 until software clears.
// - External event on the pin-selected input sets flag register 0 bit 0.
// - Flag register 0 holds bits 5, 4, 0; bit 4 read-only; reset zero.
// - Flag register 1 holds bits 7, 6, 1, 0; hardware-set, read/write, reset zero.
// - Oscillator fail-safe event sets flag register 1 bit 7 until cleared.
// - Enable register 4 bits 5 to 0 enable the six timer interrupts.
// - Enable register 5 holds logic cell and timer gate enables.
// - Enable register 6 bits 3 to 0 enable capture units four to one.
// - Enable register 7 holds memory, oscillator and waveform generator enables.
// - Enable register 8 bits 2 to 0 enable the measurement timer interrupts.
// - Global enable passes enabled interrupts to core_irq_req when 1, blocks them when 0; irq ignores it.
// - Enable register 0 sources reach the core without the peripheral enable.
// - Edge select picks rising when 1, falling when 0; resets to 1.

package pieb_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL   = 14'h000B;
  localparam logic [IDX_W-1:0] IDX_FLAG0  = 14'h070C;
  localparam logic [IDX_W-1:0] IDX_FLAG1  = 14'h070D;
  localparam logic [IDX_W-1:0] IDX_EN0    = 14'h0716;
  localparam logic [IDX_W-1:0] IDX_EN1    = 14'h0717;
  localparam logic [IDX_W-1:0] IDX_EN4    = 14'h071A;
  localparam logic [IDX_W-1:0] IDX_EN5    = 14'h071B;
  localparam logic [IDX_W-1:0] IDX_EN6    = 14'h071C;
  localparam logic [IDX_W-1:0] IDX_EN7    = 14'h071D;
  localparam logic [IDX_W-1:0] IDX_EN8    = 14'h071E;
  localparam logic [IDX_W-1:0] IDX_PINSEL = 14'h07F0;
  localparam logic [IDX_W-1:0] IDX_ISTAT  = 14'h07F1;
  localparam logic [IDX_W-1:0] IDX_IMASK  = 14'h07F2;
  localparam logic [IDX_W-1:0] IDX_STATE  = 14'h07F3;

  // ----------------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MSK_CTRL   = 8'hC1;
  localparam logic [7:0] MSK_FLAG0  = 8'h21;
  localparam logic [7:0] MSK_FLAG1  = 8'hC3;
  localparam logic [7:0] MSK_EN0    = 8'h31;
  localparam logic [7:0] MSK_EN1    = 8'hC3;
  localparam logic [7:0] MSK_EN4    = 8'h3F;
  localparam logic [7:0] MSK_EN5    = 8'hF7;
  localparam logic [7:0] MSK_EN6    = 8'h0F;
  localparam logic [7:0] MSK_EN7    = 8'h33;
  localparam logic [7:0] MSK_EN8    = 8'h07;
  localparam logic [7:0] MSK_PINSEL = 8'h07;
  localparam logic [5:0] MSK_IRQ    = 6'h3F;
  localparam logic [7:0] RST_CTRL   = 8'h01;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_PERIPH_EN  = 6;
  localparam int BIT_EDGE_SEL   = 0;
  localparam int BIT_TMR0_FLAG  = 5;
  localparam int BIT_CHG_FLAG   = 4;
  localparam int BIT_EXT_FLAG   = 0;
  localparam int BIT_OSC_FLAG   = 7;
  localparam int BIT_CSW_FLAG   = 6;
  localparam int BIT_CTHR_FLAG  = 1;
  localparam int BIT_CDONE_FLAG = 0;
  localparam int NUM_EXT_PINS   = 8;
  localparam int NUM_CHG_FLAGS  = 40;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pieb_axil_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } pieb_axil_rsp_s;

  // Peripheral event strobes, one bit per hardware-set flag except the external pin flag
  typedef struct packed {
    logic tmr0_ovf;
    logic osc_fail;
    logic clk_switch;
    logic conv_thresh;
    logic conv_done;
  } pieb_event_s;

  // Request flags of registers 4 to 8, kept by other blocks
  typedef struct packed {
    logic [7:0] flags8;
    logic [7:0] flags7;
    logic [7:0] flags6;
    logic [7:0] flags5;
    logic [7:0] flags4;
  } pieb_hiflags_s;

endpackage : pieb_pkg

//--- pieb_top.sv
// Interrupt enable and request-flag bank with an AXI4-Lite register
// slave, sticky event status with mask, and the core request.
// Assumes all inputs synchronous to aclk; event strobes may be one cycle
// or longer; flags of registers 4 to 8 arrive as levels.
//
// Decided for this implementation: the AXI4-Lite register port.

module pieb_top
  import pieb_pkg::*;
(
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Register bus
  input  wire pieb_axil_req_s           axil_req,
  output      pieb_axil_rsp_s           axil_rsp,
  // Peripheral events and flags kept elsewhere
  input  wire pieb_event_s              events,
  input  wire logic [NUM_CHG_FLAGS-1:0] per_port_change_flags,
  input  wire logic [NUM_EXT_PINS-1:0]  ext_pins,
  input  wire pieb_hiflags_s            hi_flags,
  // Interrupt outputs
  output      logic                     core_irq_req,
  output      logic                     irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Byte address to register index; low two bits ignored
  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : to_idx

  // Merge a written byte, touching only writable bits
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] wd,
                                       input logic [7:0] msk);
    return (cur & ~msk) | (wd & msk);
  endfunction : merge

  // True when an index names a mapped register
  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    return (i == IDX_CTRL)  || (i == IDX_FLAG0) || (i == IDX_FLAG1) ||
           (i == IDX_EN0)   || (i == IDX_EN1)   || (i == IDX_EN4)   ||
           (i == IDX_EN5)   || (i == IDX_EN6)   || (i == IDX_EN7)   ||
           (i == IDX_EN8)   || (i == IDX_PINSEL) || (i == IDX_ISTAT) ||
           (i == IDX_IMASK) || (i == IDX_STATE);
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic [IDX_W-1:0]  aw_idx_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;

  logic [7:0]        ctrl_r;
  logic [7:0]        flag0_r;
  logic [7:0]        flag1_r;
  logic [7:0]        en0_r;
  logic [7:0]        en1_r;
  logic [7:0]        en4_r;
  logic [7:0]        en5_r;
  logic [7:0]        en6_r;
  logic [7:0]        en7_r;
  logic [7:0]        en8_r;
  logic [7:0]        pinsel_r;
  logic [5:0]        istat_r;
  logic [5:0]        imask_r;
  logic              pin_prev_r;
  logic              core_irq_r;
  logic              irq_r;

  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_do;
  logic              wr_ok;
  logic              aw_full_nxt;
  logic              w_full_nxt;
  logic [7:0]        flag0_nxt;
  logic [7:0]        flag1_nxt;
  logic [5:0]        istat_nxt;
  logic              chg_summary;
  logic              pin_now;
  logic              ext_event;
  logic              grp0_pend;
  logic              grp_periph_pend;
  logic              core_irq_nxt;
  logic [5:0]        irq_events;
  logic [7:0]        rd_byte;

  // ----------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign aw_hs = axil_req.awvalid & awready_r;
  assign w_hs  = axil_req.wvalid & wready_r;
  // Commit once both halves are held and the last response is gone
  assign wr_do = aw_full_r & w_full_r & ~bvalid_r;
  // Only the low lane carries register data
  assign wr_ok = wr_do & wlane_r & is_mapped(aw_idx_r);

  assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_do;
  assign w_full_nxt  = (w_full_r | w_hs) & ~wr_do;

  // Holding slots for address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_idx_r  <= '0;
      wbyte_r   <= RST_ZERO;
      wlane_r   <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r  <= ~w_full_nxt;
      if (aw_hs) begin
        aw_idx_r <= to_idx(axil_req.awaddr);
      end
      if (w_hs) begin
        wbyte_r <= axil_req.wdata[7:0];
        wlane_r <= axil_req.wstrb[0];
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && axil_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control and enable registers
  // ----------------------------------------------------------------------

  // Global enable, peripheral enable, edge select (resets high)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= RST_CTRL;
    end else if (wr_ok && aw_idx_r == IDX_CTRL) begin
      ctrl_r <= merge(ctrl_r, wbyte_r, MSK_CTRL);
    end
  end

  // Enable banks; the masks keep unimplemented bits zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en0_r <= RST_ZERO;
      en1_r <= RST_ZERO;
      en4_r <= RST_ZERO;
      en5_r <= RST_ZERO;
      en6_r <= RST_ZERO;
      en7_r <= RST_ZERO;
      en8_r <= RST_ZERO;
    end else if (wr_ok) begin
      if (aw_idx_r == IDX_EN0) en0_r <= merge(en0_r, wbyte_r, MSK_EN0);
      if (aw_idx_r == IDX_EN1) en1_r <= merge(en1_r, wbyte_r, MSK_EN1);
      if (aw_idx_r == IDX_EN4) en4_r <= merge(en4_r, wbyte_r, MSK_EN4);
      if (aw_idx_r == IDX_EN5) en5_r <= merge(en5_r, wbyte_r, MSK_EN5);
      if (aw_idx_r == IDX_EN6) en6_r <= merge(en6_r, wbyte_r, MSK_EN6);
      if (aw_idx_r == IDX_EN7) en7_r <= merge(en7_r, wbyte_r, MSK_EN7);
      if (aw_idx_r == IDX_EN8) en8_r <= merge(en8_r, wbyte_r, MSK_EN8);
    end
  end

  // External input pin select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pinsel_r <= RST_ZERO;
    end else if (wr_ok && aw_idx_r == IDX_PINSEL) begin
      pinsel_r <= merge(pinsel_r, wbyte_r, MSK_PINSEL);
    end
  end

  // ----------------------------------------------------------------------
  // External edge detection
  // ----------------------------------------------------------------------
  // Re-selecting the pin can look like an edge; software clears the
  // external flag afterwards, as with any enable.
  assign pin_now   = ext_pins[pinsel_r[2:0]];
  assign ext_event = ctrl_r[BIT_EDGE_SEL] ? (pin_now & ~pin_prev_r)
                                          : (~pin_now & pin_prev_r);

  // Previous level of the selected pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_now;
    end
  end

  // ----------------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------------
  // The summary is pure logic: it drops only once every per-port
  // flag is clear; writes to it are ignored.
  assign chg_summary = |per_port_change_flags;

  // Flag register 0: software value first, hardware set wins over a clear
  always_comb begin
    flag0_nxt = flag0_r;
    if (wr_ok && aw_idx_r == IDX_FLAG0) begin
      flag0_nxt = merge(flag0_r, wbyte_r, MSK_FLAG0);
    end
    if (events.tmr0_ovf) flag0_nxt[BIT_TMR0_FLAG] = 1'b1;
    if (ext_event)       flag0_nxt[BIT_EXT_FLAG]  = 1'b1;
    flag0_nxt[BIT_CHG_FLAG] = 1'b0;
  end

  // Flag register 1: all four flags hardware-set and writable
  always_comb begin
    flag1_nxt = flag1_r;
    if (wr_ok && aw_idx_r == IDX_FLAG1) begin
      flag1_nxt = merge(flag1_r, wbyte_r, MSK_FLAG1);
    end
    if (events.osc_fail)    flag1_nxt[BIT_OSC_FLAG]   = 1'b1;
    if (events.clk_switch)  flag1_nxt[BIT_CSW_FLAG]   = 1'b1;
    if (events.conv_thresh) flag1_nxt[BIT_CTHR_FLAG]  = 1'b1;
    if (events.conv_done)   flag1_nxt[BIT_CDONE_FLAG] = 1'b1;
  end

  // Flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag0_r <= RST_ZERO;
      flag1_r <= RST_ZERO;
    end else begin
      flag0_r <= flag0_nxt;
      flag1_r <= flag1_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Core request gating
  // ----------------------------------------------------------------------
  // Stale flags are not hidden: a pending flag raises the request as
  // soon as its enable is set.
  assign grp0_pend = |({flag0_r[7:5], chg_summary, flag0_r[3:0]} & en0_r);
  assign grp_periph_pend = |(flag1_r & en1_r)
                         | |(hi_flags.flags4 & en4_r)
                         | |(hi_flags.flags5 & en5_r)
                         | |(hi_flags.flags6 & en6_r)
                         | |(hi_flags.flags7 & en7_r)
                         | |(hi_flags.flags8 & en8_r);
  assign core_irq_nxt = ctrl_r[BIT_GLOBAL_EN] &
                        (grp0_pend |
                         (ctrl_r[BIT_PERIPH_EN] & grp_periph_pend));

  // Registered request to the core, one cycle behind the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_irq_r <= 1'b0;
    end else begin
      core_irq_r <= core_irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky event status, mask and interrupt line
  // ----------------------------------------------------------------------
  assign irq_events = {events.conv_done, events.conv_thresh, events.clk_switch,
                       events.osc_fail, events.tmr0_ovf, ext_event};

  // Write one to clear; an event in the same cycle keeps the bit set
  always_comb begin
    istat_nxt = istat_r;
    if (wr_ok && aw_idx_r == IDX_ISTAT) begin
      istat_nxt = istat_r & ~(wbyte_r[5:0] & MSK_IRQ);
    end
    istat_nxt = istat_nxt | irq_events;
  end

  // Status, mask and the level interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      if (wr_ok && aw_idx_r == IDX_IMASK) begin
        imask_r <= wbyte_r[5:0] & MSK_IRQ;
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  assign ar_hs = axil_req.arvalid & arready_r;

  // Read mux; the change summary is sampled live
  always_comb begin
    rd_byte = RST_ZERO;
    unique case (to_idx(axil_req.araddr))
      IDX_CTRL:   rd_byte = ctrl_r;
      IDX_FLAG0:  rd_byte = flag0_r | (8'(chg_summary) << BIT_CHG_FLAG);
      IDX_FLAG1:  rd_byte = flag1_r;
      IDX_EN0:    rd_byte = en0_r;
      IDX_EN1:    rd_byte = en1_r;
      IDX_EN4:    rd_byte = en4_r;
      IDX_EN5:    rd_byte = en5_r;
      IDX_EN6:    rd_byte = en6_r;
      IDX_EN7:    rd_byte = en7_r;
      IDX_EN8:    rd_byte = en8_r;
      IDX_PINSEL: rd_byte = pinsel_r;
      IDX_ISTAT:  rd_byte = {2'h0, istat_r};
      IDX_IMASK:  rd_byte = {2'h0, imask_r};
      IDX_STATE:  rd_byte = {4'h0, grp0_pend, grp_periph_pend, chg_summary,
                             core_irq_r};
      default:    rd_byte = RST_ZERO;
    endcase
  end

  // One read at a time; ready drops while the data waits for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h000000, rd_byte};
      rresp_r   <= is_mapped(to_idx(axil_req.araddr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axil_req.rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign axil_rsp.awready = awready_r;
  assign axil_rsp.wready  = wready_r;
  assign axil_rsp.bvalid  = bvalid_r;
  assign axil_rsp.bresp   = bresp_r;
  assign axil_rsp.arready = arready_r;
  assign axil_rsp.rvalid  = rvalid_r;
  assign axil_rsp.rdata   = rdata_r;
  assign axil_rsp.rresp   = rresp_r;
  assign core_irq_req     = core_irq_r;
  assign irq              = irq_r;

endmodule : pieb_top

//--- pieb_monitor.sv
// Checker for the flag bank: bus answers, read-back layout, reset state.
// Assumes it is bound to pieb_top and sees only that module's ports.
module pieb_monitor
  import pieb_pkg::*;
(
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Register bus
  input wire pieb_axil_req_s           axil_req,
  input wire pieb_axil_rsp_s           axil_rsp,
  // Peripheral side
  input wire pieb_event_s              events,
  input wire logic [NUM_CHG_FLAGS-1:0] per_port_change_flags,
  input wire logic [NUM_EXT_PINS-1:0]  ext_pins,
  input wire pieb_hiflags_s            hi_flags,
  // Interrupt outputs
  input wire logic                     core_irq_req,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read in flight
  logic [ADDR_W-1:0] ra_r;
  always_ff @(posedge aclk) begin
    if (axil_req.arvalid && axil_rsp.arready) ra_r <= axil_req.araddr;
  end
  wire f0 = axil_rsp.rvalid && ra_r == {IDX_FLAG0, 2'h0};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_reset_quiet: assert property ($rose(aresetn) |-> !core_irq_req && !irq
    && !axil_rsp.bvalid) else $error("outputs active after reset");
  a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready
    |=> axil_rsp.rvalid) else $error("read not answered");
  a_write_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
    && axil_rsp.wready |-> ##2 axil_rsp.bvalid) else $error("write not answered");
  a_bresp_hold: assert property (axil_rsp.bvalid && !axil_req.bready
    |=> axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (axil_rsp.rvalid && !axil_req.rready
    |=> axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read answer dropped");
  a_upper_zero: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flag0_layout: assert property (f0 |-> axil_rsp.rdata[7:6] == 2'h0
    && axil_rsp.rdata[3:1] == 3'h0) else $error("flag0 unused bits set");
  a_flag1_layout: assert property (axil_rsp.rvalid && ra_r == {IDX_FLAG1, 2'h0}
    |-> axil_rsp.rdata[5:2] == 4'h0) else $error("flag1 unused bits set");
  a_summary_or: assert property ($rose(axil_rsp.rvalid) && f0
    && $stable(per_port_change_flags)
    |-> axil_rsp.rdata[4] == |per_port_change_flags) else $error("summary flag wrong");

  // Main scenarios reached
  c_core: cover property (core_irq_req);
  c_irq: cover property (irq);
  c_slverr: cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
endmodule : pieb_monitor

//--- pieb_periph.sv
// Model of the peripheral event sources and flag levels beside the bank.
// Assumes its tasks are called just after a rising aclk edge.
module pieb_periph
  import pieb_pkg::*;
(
  // Clock
  input  wire logic                     aclk,
  // Sources
  output pieb_event_s                   events,
  output logic [NUM_CHG_FLAGS-1:0]      per_port_change_flags,
  output logic [NUM_EXT_PINS-1:0]       ext_pins,
  output pieb_hiflags_s                 hi_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources quiet until the bench asks for activity
  initial begin
    events = '0;
    per_port_change_flags = '0;
    ext_pins = '0;
    hi_flags = '0;
  end
  // An event lasts one clock; the bank must latch it
  task automatic fire(input pieb_event_s e);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask : fire
  // Levels stand until changed; two edges let the bank settle
  task automatic set_lv(input logic [NUM_CHG_FLAGS-1:0] c, input logic [NUM_EXT_PINS-1:0] p,
                        input pieb_hiflags_s h);
    per_port_change_flags <= c;
    ext_pins <= p;
    hi_flags <= h;
    repeat (2) @(posedge aclk);
  endtask : set_lv
endmodule : pieb_periph

//--- pieb_top_bench.sv
// Self-checking bench for the flag bank through its AXI4-Lite port.
// Assumes package, design, partner model and checker compile first.
module pieb_top_bench
  import pieb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  pieb_axil_req_s req = '0;
  pieb_axil_rsp_s rsp;
  pieb_event_s    ev;
  pieb_hiflags_s  hi;
  logic [39:0]    chg;
  logic [7:0]     pins;
  logic           core_irq_req;
  logic           irq;
  int             failures = 0;
  int             n_compared = 0;
  int             cyc = 0;
  logic [13:0]    eix [8];
  logic [7:0]     emsk [8];

  always #5 aclk = ~aclk;
  pieb_top pieb_top_i (.aclk, .aresetn, .axil_req(req), .axil_rsp(rsp),
    .events(ev), .per_port_change_flags(chg), .ext_pins(pins), .hi_flags(hi),
    .core_irq_req, .irq);
  pieb_periph pieb_periph_i (.aclk, .events(ev), .per_port_change_flags(chg),
    .ext_pins(pins), .hi_flags(hi));

  // ----------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Address and data offered together; bready once the answer shows
  task automatic wr(input logic [13:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    req.awvalid <= 1'b1;
    req.awaddr <= {ix, 2'h0};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b1;
    @(posedge aclk);
    chk(32'(rsp.bresp), 32'(er), "bresp");
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] ix, input logic [7:0] e, input string m,
                    input logic [1:0] er = RESP_OKAY);
    req.arvalid <= 1'b1;
    req.araddr <= {ix, 2'h0};
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge aclk);
    chk(rsp.rdata, {24'h0, e}, m);
    chk(32'(rsp.rresp), 32'(er), "rresp");
    req.rready <= 1'b0;
  endtask : rd
  // Both request outputs are registered: allow two edges
  task automatic lvl(input logic s, input logic e, input string m);
    repeat (2) @(posedge aclk);
    chk(32'(s ? irq : core_irq_req), 32'(e), m);
  endtask : lvl
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Hang guard, far above what the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end

  initial begin
    eix = '{IDX_EN0, IDX_EN1, IDX_EN4, IDX_EN5, IDX_EN6, IDX_EN7, IDX_EN8, IDX_FLAG1};
    emsk = '{MSK_EN0, MSK_EN1, MSK_EN4, MSK_EN5, MSK_EN6, MSK_EN7, MSK_EN8, MSK_FLAG1};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, RST_CTRL, "ctrl reset");
    rd(IDX_FLAG0, RST_ZERO, "flag0 reset");
    for (int i = 0; i < 8; i++) begin
      rd(eix[i], RST_ZERO, "reset");
      wr(eix[i], 8'hFF);
      rd(eix[i], emsk[i], "bits");
      wr(eix[i], 8'h00);
    end
    wr(14'h0100, 8'hFF, RESP_SLVERR);
    rd(14'h0100, 8'h00, "unmapped", RESP_SLVERR);
    $display("test registers done");
    pieb_periph_i.fire(5'h18);
    rd(IDX_FLAG0, 8'h20, "timer flag");
    rd(IDX_FLAG1, 8'h80, "osc flag");
    lvl(1'b0, 1'b0, "gated off");
    pieb_periph_i.fire(5'h07);
    rd(IDX_FLAG1, 8'hC3, "flag1 events");
    rd(IDX_ISTAT, 8'h3E, "status");
    wr(IDX_IMASK, 8'h02);
    lvl(1'b1, 1'b1, "irq on");
    wr(IDX_ISTAT, 8'h02);
    lvl(1'b1, 1'b0, "irq off");
    rd(IDX_ISTAT, 8'h3C, "status w1c");
    wr(IDX_FLAG0, 8'h00);
    wr(IDX_FLAG1, 8'h00);
    rd(IDX_FLAG0, 8'h00, "flag0 cleared");
    $display("test events done");
    wr(IDX_EN1, 8'h80);
    wr(IDX_CTRL, 8'h81);
    pieb_periph_i.fire(5'h08);
    lvl(1'b0, 1'b0, "no peripheral enable");
    wr(IDX_CTRL, 8'hC1);
    lvl(1'b0, 1'b1, "peripheral path");
    wr(IDX_CTRL, 8'h41);
    lvl(1'b0, 1'b0, "global off");
    wr(IDX_CTRL, 8'hC1);
    wr(IDX_FLAG1, 8'h00);
    lvl(1'b0, 1'b0, "flag cleared");
    pieb_periph_i.set_lv('0, '0, 40'h01);
    wr(IDX_EN4, 8'h01);
    lvl(1'b0, 1'b1, "upper bank");
    wr(IDX_EN4, 8'h00);
    pieb_periph_i.set_lv('0, '0, '0);
    wr(IDX_EN1, 8'h00);
    wr(IDX_CTRL, 8'h81);
    wr(IDX_EN0, 8'h20);
    pieb_periph_i.fire(5'h10);
    lvl(1'b0, 1'b1, "group zero");
    wr(IDX_FLAG0, 8'h00);
    wr(IDX_EN0, 8'h00);
    wr(IDX_CTRL, 8'h01);
    $display("test gating done");
    pieb_periph_i.set_lv({1'b1, 39'h0}, '0, '0);
    rd(IDX_FLAG0, 8'h10, "summary");
    wr(IDX_FLAG0, 8'h00);
    rd(IDX_FLAG0, 8'h10, "summary held");
    pieb_periph_i.set_lv('0, '0, '0);
    rd(IDX_FLAG0, 8'h00, "summary clear");
    pieb_periph_i.set_lv('0, 8'h01, '0);
    rd(IDX_FLAG0, 8'h01, "rising edge");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_PINSEL, 8'h01);
    wr(IDX_FLAG0, 8'h00);
    pieb_periph_i.set_lv('0, 8'h03, '0);
    rd(IDX_FLAG0, 8'h00, "rise ignored");
    pieb_periph_i.set_lv('0, 8'h01, '0);
    rd(IDX_FLAG0, 8'h01, "falling on pin 1");
    $display("test change and pins done");
    results();
  end
endmodule : pieb_top_bench

bind pieb_top pieb_monitor pieb_monitor_i (.aclk, .aresetn, .axil_req, .axil_rsp, .events,
  .per_port_change_flags, .ext_pins, .hi_flags, .core_irq_req, .irq);
